// ===== dv/fhl_term_model.sv
// terminal-side model: stored password and running calendar stamp
// assumes one sys_clk and the device reset
`timescale 1ns/1ps
`default_nettype none
module fhl_term_model #(
   parameter logic [31:0] NV_PW = 32'h12345678
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // to device
   output logic [47:0] calTime,
   output logic [31:0] nvPassword
);
   typedef struct packed {
      logic [47:0] cal;
   } fhl_term_state_t;
   fhl_term_state_t state;
   fhl_term_state_t next_state;
   // ==========================================
   // calendar advances every cycle
   always_comb begin
      next_state = state;
      next_state.cal = state.cal + 48'h1;
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= fhl_term_state_t'(48'h0001_0203_0405);
      end else begin
         state <= next_state;
      end
   end
   assign calTime = state.cal;
   assign nvPassword = NV_PW;
endmodule // fhl_term_model
`default_nettype wire

// ===== dv/tb.sv
// fault history and lock bench: wishbone tasks and directed sequences
// assumes fhl_top with a short watchdog and the terminal model
`include "fhl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ==========================================
   // signals
   logic sys_clk, arst_n, wbCyc, wbStb, wbWe, wbAck, scanDone, msgValid;
   logic runMode, locked, ladderEditEn, vmemAccessEn;
   logic [7:0] wbAdr;
   logic [3:0] wbSel;
   logic [31:0] wbDatI, wbDatO, nvPassword, pwStored, rd;
   logic [15:0] msgId;
   logic [47:0] calTime, stamp;
   logic [5:0] faultFlags;
   fhl_pkg::fhl_fault_t fault;
   int err_total = 0;
   int checked = 0;
   int cyc = 0;
   logic [15:0] codes [9] = '{`FHL_E_PAR, `FHL_E_RAM, `FHL_E_CHAIN, `FHL_E_RANGE,
      `FHL_E_CFG, `FHL_E_PROG, `FHL_E_MISS, `FHL_E_BATT, `FHL_E_PWR};
   int flg [9] = '{3, 3, 4, 4, 5, 2, 4, 1, -1};
   logic [7:0] wadr [9] = '{`FHL_FATAL, `FHL_FATAL, `FHL_FATAL, `FHL_FATAL,
      `FHL_FATAL, `FHL_FATAL, `FHL_MINOR, `FHL_BATT, `FHL_CTRL};
   // ==========================================
   // design and terminal model
   fhl_top #(.WD_CYCLES(20)) fhl_top_i (.sys_clk(sys_clk), .arst_n(arst_n),
      .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
      .wbDatI(wbDatI), .wbAck(wbAck), .wbDatO(wbDatO), .fault(fault),
      .scanDone(scanDone), .msgValid(msgValid), .msgId(msgId), .calTime(calTime),
      .nvPassword(nvPassword), .runMode(runMode), .locked(locked),
      .ladderEditEn(ladderEditEn), .vmemAccessEn(vmemAccessEn),
      .faultFlags(faultFlags), .pwStored(pwStored));
   fhl_term_model fhl_term_model_i (.sys_clk(sys_clk), .arst_n(arst_n),
      .calTime(calTime), .nvPassword(nvPassword));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         err_total++;
         complete_run();
      end
   end
   // ==========================================
   // tasks
   task automatic complete_run();
      if (err_total == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbSel <= 4'hf;
      wbDatI <= d;
      do begin
         @(posedge sys_clk);
      end while (wbAck !== 1'b1);
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      // let the write settle before outputs are looked at
      @(posedge sys_clk);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic pw(input logic [31:0] p, input logic [1:0] c);
      wb(1'b1, `FHL_PWIN, p);
      wb(1'b1, `FHL_CMD, {30'h0, c});
   endtask
   task automatic pulse(input fhl_pkg::fhl_fault_t f, input logic m);
      @(posedge sys_clk);
      fault <= f;
      msgValid <= m;
      #1;
      stamp = calTime;
      @(posedge sys_clk);
      fault <= '0;
      msgValid <= 1'b0;
   endtask
   task automatic hist(input logic t, input logic [4:0] i, input logic [15:0] c);
      wb(1'b1, `FHL_HSEL, {26'h0, t, i});
      rdchk(`FHL_HCODE, {1'b1, 15'h0, c});
   endtask
   // ==========================================
   // sequence
   initial begin
      int n;
      arst_n = 1'b0;
      wbCyc = 1'b0;
      wbStb = 1'b0;
      wbWe = 1'b0;
      wbAdr = 8'h00;
      wbSel = 4'h0;
      wbDatI = 32'h0;
      scanDone = 1'b0;
      msgValid = 1'b0;
      msgId = 16'h0;
      fault = '0;
      repeat (6) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk(locked, 32'h1);
      rdchk(`FHL_PWRD, 32'h0);
      pw(32'h0, 2'h3);
      rdchk(`FHL_CMD, 32'hd);
      chk(pwStored, 32'h12345678);
      pw(32'h12345670, 2'h2);
      chk(locked, 32'h1);
      pw(32'h12345678, 2'h2);
      chk(locked, 32'h0);
      rdchk(`FHL_PWRD, 32'h12345678);
      pw(32'ha1234567, 2'h3);
      chk(pwStored, 32'ha1234567);
      wb(1'b1, `FHL_CMD, 32'h1);
      rdchk(`FHL_CMD, 32'hb);
      repeat (2) @(posedge sys_clk);
      chk({ladderEditEn, vmemAccessEn}, 32'h1);
      pw(32'ha1234567, 2'h2);
      repeat (2) @(posedge sys_clk);
      chk({ladderEditEn, locked}, 32'h2);
      pw(32'h0, 2'h3);
      chk(pwStored, 32'h0);
      wb(1'b1, `FHL_CMD, 32'h1);
      chk(locked, 32'h0);
      rdchk(`FHL_CMD, 32'h4);
      rdchk(8'hfc, 32'h0);
      wb(1'b1, `FHL_CTRL, 32'h0);
      pulse(fhl_pkg::fhl_fault_t'(9'h010), 1'b0);
      repeat (2) @(posedge sys_clk);
      chk(faultFlags, 32'h0);
      rdchk(`FHL_HCNT, 32'h0);
      wb(1'b1, `FHL_CTRL, 32'h2);
      for (int i = 0; i < 9; i++) begin
         pulse(fhl_pkg::fhl_fault_t'(9'h100 >> i), 1'b0);
         repeat (2) @(posedge sys_clk);
         chk(faultFlags, (flg[i] < 0) ? 32'h0 : 32'h1 << flg[i]);
         if (flg[i] >= 0) rdchk(wadr[i], {16'h0, codes[i]});
         hist(1'b0, 5'd0, codes[i]);
         wb(1'b1, `FHL_FLAGS, 32'h3f);
      end
      wb(1'b1, `FHL_CTRL, 32'h3);
      repeat (6) begin
         repeat (9) @(posedge sys_clk);
         scanDone <= 1'b1;
         @(posedge sys_clk);
         scanDone <= 1'b0;
      end
      chk(runMode, 32'h1);
      n = 0;
      while (runMode !== 1'b0 && n < 100) begin
         @(posedge sys_clk);
         n++;
      end
      chk(32'(n >= 15 && n <= 25), 32'h1);
      chk(faultFlags, 32'h1);
      rdchk(`FHL_FATAL, {16'h0, `FHL_E_SCAN});
      hist(1'b0, 5'd0, `FHL_E_SCAN);
      for (int i = 0; i < 23; i++) pulse(fhl_pkg::fhl_fault_t'(9'h002), 1'b0);
      repeat (2) @(posedge sys_clk);
      rdchk(`FHL_HCNT, 32'h20);
      hist(1'b0, 5'd31, `FHL_E_RAM);
      hist(1'b0, 5'd0, `FHL_E_BATT);
      rdchk(`FHL_HDATE, {16'h0, stamp[47:32]});
      rdchk(`FHL_HTIME, stamp[31:0]);
      for (int i = 1; i <= 17; i++) begin
         msgId <= 16'h0100 + 16'(i);
         pulse('0, 1'b1);
      end
      repeat (2) @(posedge sys_clk);
      rdchk(`FHL_HCNT, 32'h0010_0020);
      hist(1'b1, 5'd0, 16'h0111);
      rdchk(`FHL_HTIME, stamp[31:0]);
      hist(1'b1, 5'd15, 16'h0102);
      wb(1'b1, `FHL_HSEL, 32'h30);
      rdchk(`FHL_HCODE, 32'h0);
      // second power cycle with the password removed in the device
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk(locked, 32'h1);
      chk(pwStored, 32'h12345678);
      rdchk(`FHL_PWRD, 32'h0);
      complete_run();
   end
endmodule // tb
`default_nettype wire

// ===== rtl/fhl_map.svh
// fault history and lock: offsets, codes, field positions, timing
// assumes 32-bit classic wishbone, byte addresses, 10 MHz sys_clk
`ifndef FHL_MAP_SVH
`define FHL_MAP_SVH
// ==========================================
// register byte offsets
`define FHL_CTRL 8'h00
`define FHL_FLAGS 8'h04
`define FHL_FATAL 8'h08
`define FHL_MINOR 8'h0c
`define FHL_BATT 8'h10
`define FHL_PWIN 8'h14
`define FHL_CMD 8'h18
`define FHL_PWRD 8'h1c
`define FHL_HSEL 8'h20
`define FHL_HCODE 8'h24
`define FHL_HDATE 8'h28
`define FHL_HTIME 8'h2c
`define FHL_HCNT 8'h30
// ==========================================
// flag bit positions
`define FHL_F_SCAN 0
`define FHL_F_BATT 1
`define FHL_F_PROG 2
`define FHL_F_MEM 3
`define FHL_F_IO 4
`define FHL_F_CFG 5
// ==========================================
// history depths and error codes
`define FHL_ERR_DEPTH 32
`define FHL_MSG_DEPTH 16
`define FHL_E_SCAN 16'h0003
`define FHL_E_BATT 16'h0041
`define FHL_E_PROG 16'h0099
`define FHL_E_PAR 16'h0151
`define FHL_E_RAM 16'h0155
`define FHL_E_MISS 16'h0202
`define FHL_E_PWR 16'h0210
`define FHL_E_CHAIN 16'h0250
`define FHL_E_CFG 16'h0252
`define FHL_E_RANGE 16'h0262
`define FHL_PW_MULTI 4'ha
// ==========================================
// timing
`define FHL_CLK_HZ 10000000
`define FHL_WD_MS 200
`define FHL_WD_CYCLES (`FHL_WD_MS * `FHL_CLK_HZ / 1000)
`endif

// ===== rtl/fhl_pkg.sv
// fault history and lock: shared types
// assumes fhl_map.svh for all numeric constants
package fhl_pkg;
   // ==========================================
   // history entry: code plus calendar stamp
   typedef struct packed {
      logic [15:0] code;
      logic [47:0] stamp;
   } fhl_entry_t;
   // ==========================================
   // fault event inputs, one-cycle pulses
   typedef struct packed {
      logic parity;
      logic ramSum;
      logic ioChain;
      logic ioRange;
      logic cfgChange;
      logic progBig;
      logic ioMissing;
      logic battLow;
      logic powerDrop;
   } fhl_fault_t;
   // ==========================================
   // password commands
   typedef enum logic [1:0] {
      CMD_NONE = 2'b00,
      CMD_LOCK = 2'b01,
      CMD_UNLOCK = 2'b10,
      CMD_SETPW = 2'b11
   } fhl_cmd_t;
endpackage

// ===== rtl/fhl_top.sv
// fault history, fault flags and password lock, one wishbone slave
// assumes events as synchronous pulses and a running calendar input
// Contract
// - 32-entry error history, newest on top
// - full error history drops its oldest
// - 16-entry message history, push down
// - entries carry code, date and time
// - log user messages and system errors
// - eight digits; all zeros means none
// - leading A selects multi-level protection
// - locked after reset if password stored
// - locked device refuses password access
// - lock needs password; unlock needs match
// - scan overrun sets flag, fatal code
// - low battery sets flag, battery code
// - program too big: flag, fatal code
// - parity or ram fault: flag, code
// - missing module: io flag, minor code
// - io chain failure: flag, fatal code
// - config change if enabled: flag, code
// - io range fault: flag, fatal code
// - power drop logged, no flag
// - 200 ms watchdog ends run mode
`include "fhl_map.svh"
`timescale 1ns/1ps
`default_nettype none
module fhl_top #(
   parameter int WD_CYCLES = `FHL_WD_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // wishbone slave
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [7:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatI,
   output logic wbAck,
   output logic [31:0] wbDatO,
   // events and calendar
   input wire fhl_pkg::fhl_fault_t fault,
   input wire logic scanDone,
   input wire logic msgValid,
   input wire logic [15:0] msgId,
   input wire logic [47:0] calTime,
   input wire logic [31:0] nvPassword,
   // status
   output logic runMode,
   output logic locked,
   output logic ladderEditEn,
   output logic vmemAccessEn,
   output logic [5:0] faultFlags,
   output logic [31:0] pwStored
);
   // ==========================================
   // state
   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic run;
      logic autoCfg;
      logic [5:0] flags;
      logic [15:0] fatal;
      logic [15:0] minor;
      logic [15:0] batt;
      logic [31:0] pwIn;
      logic [31:0] pw;
      logic locked;
      logic refused;
      logic booted;
      logic ladderEn;
      logic vmemEn;
      logic [31:0] wdCnt;
      logic [5:0] hSel;
      logic [5:0] errCnt;
      logic [4:0] msgCnt;
      fhl_pkg::fhl_entry_t [`FHL_ERR_DEPTH-1:0] errHist;
      fhl_pkg::fhl_entry_t [`FHL_MSG_DEPTH-1:0] msgHist;
   } fhl_state_t;
   fhl_state_t s;
   fhl_state_t next_s;
   logic req;
   logic wr;
   logic wdHit;
   logic logErr;
   logic [15:0] logCode;
   fhl_pkg::fhl_cmd_t cmd;
   fhl_pkg::fhl_entry_t hEntry;
   logic hValid;
   function automatic logic pwDigits(input logic [27:0] p);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 7; i++) begin
         if (p[i*4 +: 4] > 4'h9) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
         input logic [3:0] m);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (m[i]) begin
            r[i*8 +: 8] = n[i*8 +: 8];
         end
      end
      return r;
   endfunction
   // ==========================================
   // bus decode and history view
   assign req = wbCyc & wbStb;
   assign wr = req & wbWe & s.ack;
   assign wdHit = s.run & ~scanDone & (s.wdCnt == 32'(WD_CYCLES - 1));
   assign cmd = fhl_pkg::fhl_cmd_t'(wbDatI[1:0]);
   always_comb begin
      if (s.hSel[5]) begin
         hValid = (s.hSel[4] == 1'b0) && ({1'b0, s.hSel[3:0]} < s.msgCnt);
         hEntry = s.msgHist[s.hSel[3:0]];
      end else begin
         hValid = ({1'b0, s.hSel[4:0]} < s.errCnt);
         hEntry = s.errHist[s.hSel[4:0]];
      end
      if (!hValid) begin
         hEntry = '0;
      end
   end
   // ==========================================
   // fault priority for the logged code
   always_comb begin
      logErr = 1'b1;
      if (fault.parity) begin
         logCode = `FHL_E_PAR;
      end else if (fault.ramSum) begin
         logCode = `FHL_E_RAM;
      end else if (fault.ioChain) begin
         logCode = `FHL_E_CHAIN;
      end else if (fault.ioRange) begin
         logCode = `FHL_E_RANGE;
      end else if (fault.cfgChange && s.autoCfg) begin
         logCode = `FHL_E_CFG;
      end else if (fault.progBig) begin
         logCode = `FHL_E_PROG;
      end else if (wdHit) begin
         logCode = `FHL_E_SCAN;
      end else if (fault.ioMissing) begin
         logCode = `FHL_E_MISS;
      end else if (fault.battLow) begin
         logCode = `FHL_E_BATT;
      end else if (fault.powerDrop) begin
         logCode = `FHL_E_PWR;
      end else begin
         logCode = 16'h0000;
         logErr = 1'b0;
      end
   end
   // ==========================================
   // next state
   always_comb begin
      next_s = s;
      next_s.ack = req & ~s.ack;
      if (!s.booted) begin
         next_s.booted = 1'b1;
         next_s.pw = nvPassword;
         next_s.locked = |nvPassword;
      end
      // watchdog
      if (!s.run || scanDone) begin
         next_s.wdCnt = 32'h0000_0000;
      end else begin
         next_s.wdCnt = s.wdCnt + 32'h0000_0001;
      end
      // register writes, flag clears first so events win
      if (wr) begin
         unique case (wbAdr)
            `FHL_CTRL: begin
               if (wbSel[0]) begin
                  next_s.run = wbDatI[0];
                  next_s.autoCfg = wbDatI[1];
               end
            end
            `FHL_FLAGS: begin
               if (wbSel[0]) begin
                  next_s.flags = s.flags & ~wbDatI[5:0];
               end
            end
            `FHL_PWIN: next_s.pwIn = merge(s.pwIn, wbDatI, wbSel);
            `FHL_HSEL: begin
               if (wbSel[0]) begin
                  next_s.hSel = wbDatI[5:0];
               end
            end
            `FHL_CMD: begin
               if (wbSel[0]) begin
                  next_s.refused = 1'b0;
                  unique case (cmd)
                     fhl_pkg::CMD_LOCK: begin
                        if (s.pw != 32'h0000_0000) begin
                           next_s.locked = 1'b1;
                        end else begin
                           next_s.refused = 1'b1;
                        end
                     end
                     fhl_pkg::CMD_UNLOCK: begin
                        if (s.pwIn == s.pw) begin
                           next_s.locked = 1'b0;
                        end else begin
                           next_s.refused = 1'b1;
                        end
                     end
                     fhl_pkg::CMD_SETPW: begin
                        if (s.locked) begin
                           next_s.refused = 1'b1;
                        end else if (pwDigits(s.pwIn[27:0]) &&
                              (s.pwIn[31:28] <= 4'h9 ||
                              s.pwIn[31:28] == `FHL_PW_MULTI)) begin
                           next_s.pw = s.pwIn;
                        end else begin
                           next_s.refused = 1'b1;
                        end
                     end
                     default: ;
                  endcase
               end
            end
            default: ;
         endcase
      end
      // fault flags and code words
      if (wdHit) begin
         next_s.run = 1'b0;
         next_s.wdCnt = 32'h0000_0000;
         next_s.flags[`FHL_F_SCAN] = 1'b1;
         next_s.fatal = `FHL_E_SCAN;
      end
      if (fault.battLow) begin
         next_s.flags[`FHL_F_BATT] = 1'b1;
         next_s.batt = `FHL_E_BATT;
      end
      if (fault.ioMissing) begin
         next_s.flags[`FHL_F_IO] = 1'b1;
         next_s.minor = `FHL_E_MISS;
      end
      if (fault.progBig) begin
         next_s.flags[`FHL_F_PROG] = 1'b1;
      end
      if (fault.parity || fault.ramSum) begin
         next_s.flags[`FHL_F_MEM] = 1'b1;
      end
      if (fault.ioChain || fault.ioRange) begin
         next_s.flags[`FHL_F_IO] = 1'b1;
      end
      if (fault.cfgChange && s.autoCfg) begin
         next_s.flags[`FHL_F_CFG] = 1'b1;
      end
      if (logErr && logCode != `FHL_E_BATT && logCode != `FHL_E_MISS &&
            logCode != `FHL_E_PWR) begin
         next_s.fatal = logCode;
      end
      // history push-down
      if (logErr) begin
         for (int i = `FHL_ERR_DEPTH - 1; i > 0; i--) begin
            next_s.errHist[i] = s.errHist[i-1];
         end
         next_s.errHist[0] = '{code: logCode, stamp: calTime};
         if (s.errCnt != 6'(`FHL_ERR_DEPTH)) begin
            next_s.errCnt = s.errCnt + 6'h01;
         end
      end
      if (msgValid) begin
         for (int i = `FHL_MSG_DEPTH - 1; i > 0; i--) begin
            next_s.msgHist[i] = s.msgHist[i-1];
         end
         next_s.msgHist[0] = '{code: msgId, stamp: calTime};
         if (s.msgCnt != 5'(`FHL_MSG_DEPTH)) begin
            next_s.msgCnt = s.msgCnt + 5'h01;
         end
      end
      // access levels follow the lock
      next_s.ladderEn = ~next_s.locked;
      next_s.vmemEn = ~next_s.locked || (next_s.pw[31:28] == `FHL_PW_MULTI);
      // read data
      next_s.rdat = 32'h0000_0000;
      if (req && !s.ack) begin
         unique case (wbAdr)
            `FHL_CTRL: next_s.rdat = {23'h0, s.run, 6'h00, s.autoCfg, s.run};
            `FHL_FLAGS: next_s.rdat = {26'h0, s.flags};
            `FHL_FATAL: next_s.rdat = {16'h0, s.fatal};
            `FHL_MINOR: next_s.rdat = {16'h0, s.minor};
            `FHL_BATT: next_s.rdat = {16'h0, s.batt};
            `FHL_PWIN: next_s.rdat = s.pwIn;
            `FHL_CMD: next_s.rdat = {28'h0, |s.pw, s.refused,
               s.pw[31:28] == `FHL_PW_MULTI, s.locked};
            `FHL_PWRD: next_s.rdat = s.locked ? 32'h0000_0000 : s.pw;
            `FHL_HSEL: next_s.rdat = {26'h0, s.hSel};
            `FHL_HCODE: next_s.rdat = {hValid, 15'h0, hEntry.code};
            `FHL_HDATE: next_s.rdat = {16'h0, hEntry.stamp[47:32]};
            `FHL_HTIME: next_s.rdat = hEntry.stamp[31:0];
            `FHL_HCNT: next_s.rdat = {11'h0, s.msgCnt, 10'h0, s.errCnt};
            default: next_s.rdat = 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   // ==========================================
   // outputs
   assign wbAck = s.ack;
   assign wbDatO = s.rdat;
   assign runMode = s.run;
   assign locked = s.locked;
   assign ladderEditEn = s.ladderEn;
   assign vmemAccessEn = s.vmemEn;
   assign faultFlags = s.flags;
   assign pwStored = s.pw;
   // ==========================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   property p_err_push;
      logErr |=> s.errHist[0].code == $past(logCode) &&
         s.errHist[1] == $past(s.errHist[0]);
   endproperty
   a_err_push: assert property (p_err_push) else $error("error push");
   property p_err_drop;
      logErr |=> s.errHist[31] == $past(s.errHist[30]) && s.errCnt <= 6'h20;
   endproperty
   a_err_drop: assert property (p_err_drop) else $error("error drop");
   property p_msg_push;
      msgValid |=> s.msgHist[0].code == $past(msgId) &&
         s.msgHist[0].stamp == $past(calTime);
   endproperty
   a_msg_push: assert property (p_msg_push) else $error("message push");
   property p_boot_lock;
      !s.booted |=> s.locked == (|$past(nvPassword));
   endproperty
   a_boot_lock: assert property (p_boot_lock) else $error("boot lock");
   property p_setpw_locked;
      s.locked && wr && wbAdr == `FHL_CMD && wbSel[0] && cmd == fhl_pkg::CMD_SETPW
         |=> s.pw == $past(s.pw) && s.refused;
   endproperty
   a_setpw_locked: assert property (p_setpw_locked) else $error("pw changed");
   property p_lock_nopw;
      s.booted && !s.locked && s.pw == 32'h0 && wr && wbAdr == `FHL_CMD &&
         wbSel[0] && cmd == fhl_pkg::CMD_LOCK |=> !s.locked ##1 !s.locked;
   endproperty
   a_lock_nopw: assert property (p_lock_nopw) else $error("lock no pw");
   property p_wdog;
      wdHit |=> !s.run && s.fatal != 16'h0 && s.flags[`FHL_F_SCAN] && s.wdCnt == 32'h0;
   endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog");
   property p_batt;
      fault.battLow |=> s.flags[`FHL_F_BATT] && s.batt == `FHL_E_BATT;
   endproperty
   a_batt: assert property (p_batt) else $error("battery");
   property p_multi;
      s.booted && s.locked && s.pw[31:28] == `FHL_PW_MULTI |-> s.vmemEn && !s.ladderEn;
   endproperty
   a_multi: assert property (p_multi) else $error("multi level");
   c_full: cover property (logErr && s.errCnt == 6'h20);
   c_unlock: cover property (s.locked ##1 !s.locked);
   c_wdog: cover property (wdHit);
endmodule // fhl_top
`default_nettype wire
